// file: bench/sarctl_comp_model.sv
// comparator with held input level, facing the converter array
`timescale 1ns/1ps
module sarctl_comp_model (
   input wire logic clk,
   input wire logic sample_track,
   input wire logic [11:0] trial_code,
   input wire logic [11:0] level,
   output logic comp_out
);
   logic [11:0] held_r;
   always_ff @(posedge clk) begin
      if (sample_track) begin
         held_r <= level;
      end
   end
   assign comp_out = held_r >= trial_code;
endmodule // sarctl_comp_model

// file: bench/sarctl_top_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module sarctl_top_bench;
   import sarctl_pkg::*;
   typedef struct {logic [11:0] lvl; logic len8; logic [11:0] res;} sarctl_row_t;
   logic clk = 0, rst = 1, en = 0, cs_n = 1, rnc = 1, bsel = 0, wsel = 1, comp_out;
   logic [11:0] level = 12'h000, trial_code, result_bus_o, result_bus_oe;
   logic sample_track, status;
   int n_fail = 0, compares = 0;
   sarctl_row_t rows[6] = '{'{12'h000, 0, 12'h000}, '{12'hfff, 0, 12'hfff},
      '{12'h800, 0, 12'h800}, '{12'h7ff, 0, 12'h7ff}, '{12'ha5c, 1, 12'ha50},
      '{12'h3c7, 1, 12'h3c0}};
   always #4 clk = ~clk;
   sarctl_top #(.STEP_CYC(2)) DUT (.clk(clk), .rst(rst), .enable_high_strobe(en),
      .select_low_n(cs_n), .read_not_convert(rnc), .byte_or_length_sel(bsel),
      .word_width_sel(wsel), .comp_out(comp_out), .trial_code(trial_code),
      .sample_track(sample_track), .status(status), .result_bus_o(result_bus_o),
      .result_bus_oe(result_bus_oe));
   sarctl_comp_model u_comp (.clk(clk), .sample_track(sample_track), .trial_code(trial_code),
      .level(level), .comp_out(comp_out));
   task automatic check(input logic [11:0] seen, input logic [11:0] want);
      compares++;
      if (seen !== want) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_idle;
      for (int i = 0; i < 300 && status !== 1'b0; i++) begin
         tick(1);
      end
      check(status, 1'b0);
   endtask
   task automatic rd(input logic w, input logic s, input logic [11:0] d, input logic [11:0] e);
      wsel = w;
      bsel = s;
      rnc = 1;
      en = 1;
      cs_n = 0;
      tick(1);
      check(result_bus_oe, e);
      check(result_bus_o & e, d);
   endtask
   // start, then a stray convert pulse while busy
   task automatic conv(input logic len);
      en = 1;
      cs_n = 0;
      rnc = 0;
      bsel = len;
      tick(1);
      check(status, 1'b1);
      rnc = 1;
      tick(2);
      rnc = 0;
      tick(1);
      rnc = 1;
      wait_idle;
   endtask
   task automatic end_of_test;
      if (n_fail == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #200000;
      n_fail++;
      end_of_test;
   end
   initial begin
      tick(5);
      rst = 0;
      foreach (rows[i]) begin
         level = rows[i].lvl;
         tick(1);
         conv(rows[i].len8);
         rd(1'b1, 1'b0, rows[i].res, 12'hfff);
         rd(1'b0, 1'b0, {rows[i].res[11:4], 4'h0}, 12'hff0);
         rd(1'b0, 1'b1, {rows[i].res[3:0], 8'h00}, 12'hff0);
      end
      for (int k = 0; k < 3; k++) begin
         level = 12'h5a3 + 12'(k);
         en = (k != 0);
         cs_n = (k == 1);
         rnc = (k == 2);
         bsel = 0;
         tick(2);
         check(status, 1'b0);
         en = 1;
         cs_n = 0;
         rnc = 0;
         tick(1);
         check(status, 1'b1);
         rnc = 1;
         wait_idle;
         rd(1'b1, 1'b0, level, 12'hfff);
      end
      conv(1'b0);
      rnc = 0;
      tick(3);
      rst = 1;
      tick(1);
      rst = 0;
      tick(3);
      check({status, sample_track}, 2'b01);
      check(result_bus_oe, 12'h000);
      end_of_test;
   end
endmodule // sarctl_top_bench

// file: bench/sarctl_top_properties.sv
// port checker for the converter control block
`timescale 1ns/1ps
module sarctl_top_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic enable_high_strobe,
   input wire logic select_low_n,
   input wire logic read_not_convert,
   input wire logic word_width_sel,
   input wire logic sample_track,
   input wire logic status,
   input wire logic [11:0] result_bus_o,
   input wire logic [11:0] result_bus_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire rd_ok = read_not_convert && !status && enable_high_strobe && !select_low_n;
   property p_busy; $fell(sample_track) |=> status [*8]; endproperty
   a_busy: assert property (p_busy) else $error("status low in conversion");
   property p_float; status |-> result_bus_oe == 12'h000; endproperty
   a_float: assert property (p_float) else $error("bus driven while busy");
   property p_hold; status && sample_track |=> sample_track || !status; endproperty
   a_hold: assert property (p_hold) else $error("start taken while busy");
   property p_track; $rose(sample_track) && !$past(rst) |-> status; endproperty
   a_track: assert property (p_track) else $error("tracking late");
   property p_thru; $fell(sample_track) |-> ##[1:1000] !status; endproperty
   a_thru: assert property (p_thru) else $error("conversion too long");
   property p_word; rd_ok && word_width_sel |=> result_bus_oe == 12'hfff; endproperty
   a_word: assert property (p_word) else $error("word not driven");
   property p_byte; rd_ok && !word_width_sel |=> result_bus_oe == 12'hff0; endproperty
   a_byte: assert property (p_byte) else $error("byte lanes wrong");
   property p_off; !rd_ok |=> result_bus_oe == 12'h000; endproperty
   a_off: assert property (p_off) else $error("bus not floating");
   property p_lowz; result_bus_oe == 12'hff0 |-> result_bus_o[3:0] == 4'h0; endproperty
   a_lowz: assert property (p_lowz) else $error("low nibble not zero");
   property p_idle; $fell(rst) |-> !status && sample_track; endproperty
   a_idle: assert property (p_idle) else $error("not idle after reset");
endmodule // sarctl_top_chk
bind sarctl_top sarctl_top_chk u_chk (.*);

// file: hdl/sarctl_pkg.sv
// constants for the sampling converter control logic
package sarctl_pkg;
   localparam int RES_BITS = 12;
   localparam int SHORT_BITS = 8;
   localparam int CLK_PERIOD_NS = 8;
   // least convert-low time
   localparam int CONV_LOW_NS = 25;
   localparam int CONV_LOW_CYC = (CONV_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // longest throughput: conversion plus next acquisition
   localparam int THRU_MAX_NS = 8500;
   localparam int THRU_MAX_CYC = THRU_MAX_NS / CLK_PERIOD_NS;
   // acquisition time allowed after a conversion
   localparam int ACQ_NS = 1400;
   localparam int ACQ_CYC = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // cycles per approximation step
   localparam int STEP_CYC_DEF = 8;
   // status falls this many cycles after the result is latched
   localparam int STS_LAG_CYC = 2;
   localparam logic [11:0] RES_RESET = 12'h000;
   localparam logic [3:0] NIBBLE_ZERO = 4'h0;
   typedef enum logic [2:0] {
      SARCTL_TRACK = 3'b001,
      SARCTL_CONV = 3'b010,
      SARCTL_DONE = 3'b100
   } sarctl_state_t;
endpackage

// file: hdl/sarctl_top.sv
// control and host interface of a 12-bit successive-approximation converter
`timescale 1ns/1ps
// Notes on behaviour
// - convert-low edge holds input, starts conversion
// - status high throughout conversion until data latched; here it falls STS_LAG_CYC (2) cycles after the latch
// - bus floats, starts ignored while converting
// - track again as soon as conversion ends
// - conversion plus acquisition within 8.5 us
// - enable must be high; rising edge starts
// - select must be low; falling edge starts
// - read_not_convert low starts conversion
// - read_not_convert high for reading data
// - byte select at start: 1 short, 0 full
// - byte read: 0 upper eight, 1 low nibble
// - word width high drives all twelve bits
// - low byte left justified, zero lower nibble
// - stand-alone: only read_not_convert toggles
// - result is straight binary code
// - approximation from msb down, comparator decides
// - length latched at start; short leaves lsbs zero
// - last of three controls starts conversion
// - bus driven only when all four conditions hold
module sarctl_top
   import sarctl_pkg::*;
#(
   parameter int STEP_CYC = STEP_CYC_DEF
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic enable_high_strobe,
   input wire logic select_low_n,
   input wire logic read_not_convert,
   input wire logic byte_or_length_sel,
   input wire logic word_width_sel,
   input wire logic comp_out,
   output logic [11:0] trial_code,
   output logic sample_track,
   output logic status,
   output logic [11:0] result_bus_o,
   output logic [11:0] result_bus_oe
);
   // ---------------------------------------------
   // elaboration checks
   // ---------------------------------------------
   initial begin
      if (STEP_CYC < 1 || STEP_CYC > 255) begin
         $error("sarctl_top: STEP_CYC out of range");
      end
      if (STEP_CYC * (RES_BITS + 1) + STS_LAG_CYC + ACQ_CYC > THRU_MAX_CYC) begin
         $error("sarctl_top: throughput exceeds limit");
      end
      if (SHORT_BITS < 1 || SHORT_BITS > RES_BITS) begin
         $error("sarctl_top: short length out of range");
      end
      if (RES_BITS != 12) begin
         $error("sarctl_top: result width must be twelve");
      end
      if (CONV_LOW_CYC > 15) begin
         $error("sarctl_top: low-time count exceeds counter");
      end
      if (STS_LAG_CYC < 1 || STS_LAG_CYC > 3) begin
         $error("sarctl_top: status lag out of range");
      end
   end

   // ---------------------------------------------
   // start detection
   // ---------------------------------------------
   logic start_ok_now;
   logic start_ok_r;
   logic start_evt;
   logic rnc_low_long;
   logic [3:0] low_cnt_r;
   logic [3:0] low_cnt_nxt;
   sarctl_state_t state_r;
   sarctl_state_t state_nxt;

   logic en_ok;
   logic sel_ok;
   logic conv_req;

   assign en_ok = enable_high_strobe;
   assign sel_ok = ~select_low_n;
   assign conv_req = ~read_not_convert;
   // all three controls in the convert state
   assign start_ok_now = en_ok & sel_ok & conv_req;
   // the last control to arrive makes the edge
   assign start_evt = start_ok_now & ~start_ok_r & (state_r == SARCTL_TRACK);
   assign low_cnt_nxt = read_not_convert ? 4'h0 :
      ((low_cnt_r == 4'hf) ? low_cnt_r : low_cnt_r + 4'h1);
   assign rnc_low_long = (low_cnt_r >= 4'(CONV_LOW_CYC));

   always_ff @(posedge clk) begin
      if (rst) begin
         start_ok_r <= 1'b1;
      end else begin
         start_ok_r <= start_ok_now;
      end
   end

   // low time of the convert request
   always_ff @(posedge clk) begin
      if (rst) begin
         low_cnt_r <= 4'h0;
      end else begin
         low_cnt_r <= low_cnt_nxt;
      end
   end

   // ---------------------------------------------
   // approximation sequencer
   // ---------------------------------------------
   logic short_r;
   logic [3:0] bit_idx_r;
   logic [3:0] bit_idx_nxt;
   logic [7:0] step_cnt_r;
   logic [7:0] step_cnt_nxt;
   logic [11:0] sar_r;
   logic [11:0] sar_nxt;
   logic [11:0] res_r;
   logic [11:0] res_nxt;
   logic [1:0] lag_r;
   logic [1:0] lag_nxt;
   logic step_end;
   logic last_bit;
   logic [3:0] stop_idx;

   function automatic logic [11:0] bit_mask(input logic [3:0] idx);
      bit_mask = 12'h001 << idx;
   endfunction

   // ---------------------------------------------
   // approximation step decode
   // ---------------------------------------------
   logic conv_step;
   logic [11:0] cur_mask;

   assign step_end = (step_cnt_r == 8'(STEP_CYC - 1));
   // one approximation step ends in this cycle
   assign conv_step = (state_r == SARCTL_CONV) & step_end;
   assign cur_mask = bit_mask(bit_idx_r);
   assign stop_idx = short_r ? 4'(RES_BITS - SHORT_BITS) : 4'h0;
   assign last_bit = (bit_idx_r == stop_idx);
   assign bit_idx_nxt = start_evt ? 4'(RES_BITS - 1) :
      ((conv_step && !last_bit) ? bit_idx_r - 4'h1 : bit_idx_r);
   assign step_cnt_nxt = (start_evt || step_end) ? 8'h00 : step_cnt_r + 8'h01;

   always_comb begin
      sar_nxt = sar_r;
      if (start_evt) begin
         sar_nxt = RES_RESET;
      end else if (conv_step) begin
         if (comp_out) begin
            // input at or above the trial: keep the bit
            sar_nxt = sar_r | cur_mask;
         end else begin
            // trial too large: leave the bit clear
            sar_nxt = sar_r & ~cur_mask;
         end
      end
   end

   // trial code shown to the comparator: kept bits plus the bit under test
   assign trial_code = sar_r | ((state_r == SARCTL_CONV) ? cur_mask : RES_RESET);

   // ---------------------------------------------
   // result latch and status lag
   // ---------------------------------------------

   always_comb begin
      state_nxt = state_r;
      res_nxt = res_r;
      lag_nxt = lag_r;
      unique case (state_r)
         SARCTL_TRACK: begin
            if (start_evt) begin
               state_nxt = SARCTL_CONV;
            end
         end
         SARCTL_CONV: begin
            if (step_end && last_bit) begin
               // straight binary; short conversions keep lsbs zero
               res_nxt = sar_nxt;
               lag_nxt = 2'(STS_LAG_CYC);
               state_nxt = SARCTL_DONE;
            end
         end
         SARCTL_DONE: begin
            if (lag_r == 2'd1 || lag_r == 2'd0) begin
               state_nxt = SARCTL_TRACK;
            end else begin
               lag_nxt = lag_r - 2'd1;
            end
         end
         default: state_nxt = SARCTL_TRACK;
      endcase
   end

   // ---------------------------------------------
   // sequencer registers
   // ---------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= SARCTL_TRACK;
         lag_r <= 2'd0;
      end else begin
         state_r <= state_nxt;
         lag_r <= lag_nxt;
      end
   end

   // conversion length is taken only at the start edge
   always_ff @(posedge clk) begin
      if (rst) begin
         short_r <= 1'b0;
      end else if (start_evt) begin
         short_r <= byte_or_length_sel;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         bit_idx_r <= 4'h0;
         step_cnt_r <= 8'h00;
      end else begin
         bit_idx_r <= bit_idx_nxt;
         step_cnt_r <= step_cnt_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sar_r <= RES_RESET;
         res_r <= RES_RESET;
      end else begin
         sar_r <= sar_nxt;
         res_r <= res_nxt;
      end
   end

   // ---------------------------------------------
   // status, sampling and output drive
   // ---------------------------------------------
   logic status_r;
   logic read_ok;
   logic [11:0] oe_nxt;
   logic [11:0] data_nxt;
   logic [11:0] oe_r;
   logic [11:0] data_r;

   // hold from the start edge; track again once the result is latched
   assign sample_track = (state_r != SARCTL_CONV) & ~start_evt;
   assign status = status_r;
   assign read_ok = read_not_convert & ~status_r & enable_high_strobe & ~select_low_n
      & ~start_evt;

   // ---------------------------------------------
   // read lane decode
   // ---------------------------------------------
   logic [11:0] word_data;
   logic [11:0] hi_byte_data;
   logic [11:0] lo_byte_data;
   logic [11:0] byte_data;
   logic [11:0] read_oe;

   assign word_data = res_r;
   // byte mode uses lanes 11:4 only; lanes 3:0 stay zero
   assign hi_byte_data = {res_r[11:4], NIBBLE_ZERO};
   assign lo_byte_data = {res_r[3:0], NIBBLE_ZERO, NIBBLE_ZERO};
   assign byte_data = byte_or_length_sel ? lo_byte_data : hi_byte_data;
   assign data_nxt = word_width_sel ? word_data : byte_data;
   assign read_oe = word_width_sel ? 12'hfff : 12'hff0;
   assign oe_nxt = read_ok ? read_oe : 12'h000;

   always_ff @(posedge clk) begin
      if (rst) begin
         status_r <= 1'b0;
      end else begin
         status_r <= start_evt | (state_nxt != SARCTL_TRACK);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         oe_r <= 12'h000;
         data_r <= RES_RESET;
      end else begin
         oe_r <= oe_nxt;
         data_r <= data_nxt;
      end
   end

   assign result_bus_o = data_r;
   assign result_bus_oe = oe_r;
   // low-time counter kept for the hold request width
   logic unused_ok;
   assign unused_ok = rnc_low_long;
endmodule // sarctl_top
